// [hdl/ebt_break_trace.v]
// break comparators, trace buffer, sync lines and emulation timer of an emulator
// assumes: core strobes step_done once per completed instruction with its bus values;
// fetch_strobe marks operand fetches; sync_in is an asynchronous pin
`include "ebt_consts.vh"
`default_nettype none

module ebt_break_trace (
   // clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // emulation core
   input  wire        step_done,
   input  wire [15:0] exec_addr,
   input  wire [7:0]  exec_opcode,
   input  wire [7:0]  exec_port,
   input  wire        fetch_strobe,
   input  wire [15:0] fetch_addr,
   input  wire [7:0]  fetch_operand,
   output wire        core_run,
   output reg         halted,
   // sync lines
   input  wire        sync_in,
   output reg         sync_out
);

   // compare word: lo = {addr_hi[15:0], addr_lo[15:0]}, hi = {kind, value8}
   function cmp_hit;
      input [31:0] lo;
      input [10:0] hi;
      input [15:0] ea;
      input [7:0]  op;
      input [7:0]  pt;
      input        fs;
      input [15:0] fa;
      input [7:0]  fo;
      begin
         case (hi[10:8])
            `EBT_KIND_EXACT:  cmp_hit = step_done && ea == lo[15:0];
            `EBT_KIND_RANGE:  cmp_hit = step_done && ea >= lo[15:0] && ea <= lo[31:16];
            `EBT_KIND_OPCODE: cmp_hit = step_done && op == hi[7:0];
            `EBT_KIND_PORT:   cmp_hit = pt == hi[7:0];
            `EBT_KIND_OPVAL:  cmp_hit = fs && fo == hi[7:0];
            `EBT_KIND_OPADDR: cmp_hit = fs && fa == lo[15:0];
            default:          cmp_hit = 1'b0;
         endcase
      end
   endfunction

   // pin synchroniser
   reg        sync_meta_reg;
   reg        sync_in_reg;
   reg        sync_prev_reg;
   // control
   reg        run_reg;
   reg        step_reg;
   reg        arm0_reg;
   reg        arm1_reg;
   reg        brk_pend_reg;
   reg [1:0]  brk_src_reg;
   reg [31:0] brk_lo_reg   [0:1];
   reg [10:0] brk_hi_reg   [0:1];
   reg [31:0] qual_lo_reg  [0:1];
   reg [10:0] qual_hi_reg  [0:1];
   reg [1:0]  tmode_reg;
   reg        tr_en_reg;
   reg        trig_seen_reg;
   reg [`EBT_TR_W-1:0]  trace_mem [0:`EBT_TR_DEPTH-1];
   reg [`EBT_TR_AW-1:0] wr_ptr_reg;
   reg [`EBT_TR_AW-1:0] rd_ptr_reg;
   reg [`EBT_TR_AW:0]   count_reg;
   reg [3:0]  us_div_reg;
   reg [31:0] timer_reg;
   reg        sync_latch_reg;
   reg        sync_runen_reg;
   reg        sync_trcen_reg;

   wire [1:0] brk_hit;
   wire [1:0] qual_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
         // each comparator sees every cycle's live values
         assign brk_hit[gi]  = cmp_hit(brk_lo_reg[gi], brk_hi_reg[gi], exec_addr,
                                       exec_opcode, exec_port, fetch_strobe,
                                       fetch_addr, fetch_operand);
         assign qual_hit[gi] = cmp_hit(qual_lo_reg[gi], qual_hi_reg[gi], exec_addr,
                                       exec_opcode, exec_port, fetch_strobe,
                                       fetch_addr, fetch_operand);
      end
   endgenerate

   wire brk_any  = (arm0_reg && brk_hit[0]) || (arm1_reg && brk_hit[1]);
   wire qual_any = |qual_hit;
   wire wr_ctrl  = reg_wr && reg_addr == `EBT_REG_CTRL;
   wire sync_rise = sync_in_reg && !sync_prev_reg;
   wire sync_fall = !sync_in_reg && sync_prev_reg;

   assign core_run = run_reg || step_reg;

   // trace store decision
   reg store;
   always @* begin
      case (tmode_reg)
         `EBT_TM_FOREVER: store = 1'b1;
         `EBT_TM_QUAL:    store = qual_any;
         `EBT_TM_PRE:     store = !trig_seen_reg && !qual_any;
         // the matching step itself is not part of the post-trigger record
         `EBT_TM_POST:    store = trig_seen_reg;
         default:         store = 1'b0;
      endcase
      store = store && step_done && tr_en_reg;
   end

   // trace storage has no reset: contents are only valid up to count_reg
   always @(posedge clock) begin
      if (store)
         trace_mem[wr_ptr_reg] <= {exec_port, exec_opcode, exec_addr, 8'h00};
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_meta_reg  <= 1'b0;
         sync_in_reg    <= 1'b0;
         sync_prev_reg  <= 1'b0;
         run_reg        <= 1'b0;
         step_reg       <= 1'b0;
         halted         <= 1'b1;
         arm0_reg       <= 1'b0;
         arm1_reg       <= 1'b0;
         brk_pend_reg   <= 1'b0;
         brk_src_reg    <= 2'h0;
         brk_lo_reg[0]  <= 32'h0;
         brk_lo_reg[1]  <= 32'h0;
         brk_hi_reg[0]  <= 11'h0;
         brk_hi_reg[1]  <= 11'h0;
         qual_lo_reg[0] <= 32'h0;
         qual_lo_reg[1] <= 32'h0;
         qual_hi_reg[0] <= 11'h0;
         qual_hi_reg[1] <= 11'h0;
         tmode_reg      <= `EBT_TM_FOREVER;
         tr_en_reg      <= 1'b1;
         trig_seen_reg  <= 1'b0;
         wr_ptr_reg     <= {`EBT_TR_AW{1'b0}};
         rd_ptr_reg     <= {`EBT_TR_AW{1'b0}};
         count_reg      <= {(`EBT_TR_AW+1){1'b0}};
         us_div_reg     <= 4'h0;
         timer_reg      <= 32'h0;
         sync_out       <= 1'b0;
         sync_latch_reg <= 1'b0;
         sync_runen_reg <= 1'b0;
         sync_trcen_reg <= 1'b0;
         reg_rdata      <= 32'h0;
      end else begin
         sync_meta_reg <= sync_in;
         sync_in_reg   <= sync_meta_reg;
         sync_prev_reg <= sync_in_reg;
         // latched input: set wins over host clear
         if (sync_rise)
            sync_latch_reg <= 1'b1;
         else if (reg_wr && reg_addr == `EBT_REG_SYNC && reg_wdata[`EBT_SYNC_LATCH])
            sync_latch_reg <= 1'b0;

         // breaks take effect only at instruction completion
         if (core_run && brk_any)
            brk_pend_reg <= 1'b1;
         step_reg <= 1'b0;
         if (core_run && step_done && (brk_pend_reg || brk_any)) begin
            run_reg      <= 1'b0;
            halted       <= 1'b1;
            brk_pend_reg <= 1'b0;
            brk_src_reg  <= {arm1_reg && brk_hit[1], arm0_reg && brk_hit[0]};
         end else if (step_reg && step_done) begin
            halted <= 1'b1;
         end else if (wr_ctrl && reg_wdata[`EBT_CTRL_HALT]) begin
            run_reg <= 1'b0;
            halted  <= 1'b1;
         end else if (sync_runen_reg && sync_fall && run_reg) begin
            run_reg <= 1'b0;
            halted  <= 1'b1;
         end else if (halted && ((wr_ctrl && reg_wdata[`EBT_CTRL_RUN]) ||
                                 (sync_runen_reg && sync_rise))) begin
            run_reg      <= 1'b1;
            halted       <= 1'b0;
            brk_src_reg  <= 2'h0;
            brk_pend_reg <= 1'b0;
            if (wr_ctrl) begin
               arm0_reg <= reg_wdata[`EBT_CTRL_ARM0];
               arm1_reg <= reg_wdata[`EBT_CTRL_ARM1];
            end
         end else if (halted && wr_ctrl && reg_wdata[`EBT_CTRL_STEP]) begin
            step_reg <= 1'b1;
            halted   <= 1'b0;
         end
         // a halt command also ends a pending single step
         if (step_reg && !step_done && !(wr_ctrl && reg_wdata[`EBT_CTRL_HALT]))
            step_reg <= 1'b1;

         // microsecond timer runs only while emulating
         if (core_run) begin
            if (us_div_reg == `EBT_US_LAST) begin
               us_div_reg <= 4'h0;
               timer_reg  <= timer_reg + 32'h1;
            end else begin
               us_div_reg <= us_div_reg + 4'h1;
            end
         end

         // sync input edges switch trace on and off when coupled
         if (sync_trcen_reg && sync_rise)
            tr_en_reg <= 1'b1;
         else if (sync_trcen_reg && sync_fall)
            tr_en_reg <= 1'b0;

         if (step_done && qual_any)
            trig_seen_reg <= 1'b1;
         if (store) begin
            wr_ptr_reg <= (wr_ptr_reg == `EBT_TR_LAST) ? {`EBT_TR_AW{1'b0}}
                                                       : wr_ptr_reg + 10'h1;
            if (count_reg != `EBT_TR_DEPTH)
               count_reg <= count_reg + 11'h1;
         end

         if (reg_wr) begin
            case (reg_addr)
               `EBT_REG_CTRL: begin
                  if (reg_wdata[`EBT_CTRL_TCLR]) begin
                     wr_ptr_reg    <= {`EBT_TR_AW{1'b0}};
                     count_reg     <= {(`EBT_TR_AW+1){1'b0}};
                     // a match in the same cycle wins over the clear
                     trig_seen_reg <= step_done && qual_any;
                     timer_reg     <= 32'h0;
                     us_div_reg    <= 4'h0;
                  end
               end
               `EBT_REG_BRK0_LO:  brk_lo_reg[0]  <= reg_wdata;
               `EBT_REG_BRK0_HI:  brk_hi_reg[0]  <= reg_wdata[10:0];
               `EBT_REG_BRK1_LO:  brk_lo_reg[1]  <= reg_wdata;
               `EBT_REG_BRK1_HI:  brk_hi_reg[1]  <= reg_wdata[10:0];
               `EBT_REG_QUAL0_LO: qual_lo_reg[0] <= reg_wdata;
               `EBT_REG_QUAL0_HI: qual_hi_reg[0] <= reg_wdata[10:0];
               `EBT_REG_QUAL1_LO: qual_lo_reg[1] <= reg_wdata;
               `EBT_REG_QUAL1_HI: qual_hi_reg[1] <= reg_wdata[10:0];
               `EBT_REG_TRCFG: begin
                  tmode_reg     <= reg_wdata[1:0];
                  tr_en_reg     <= reg_wdata[2];
                  trig_seen_reg <= step_done && qual_any;
               end
               `EBT_REG_TRPTR:
                  rd_ptr_reg <= (reg_wdata[9:0] > `EBT_TR_LAST) ? `EBT_TR_LAST
                                                               : reg_wdata[9:0];
               `EBT_REG_SYNC: begin
                  sync_out       <= reg_wdata[`EBT_SYNC_OUT];
                  sync_runen_reg <= reg_wdata[`EBT_SYNC_RUNEN];
                  sync_trcen_reg <= reg_wdata[`EBT_SYNC_TRCEN];
               end
               default: ;
            endcase
         end

         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `EBT_REG_CTRL:     reg_rdata <= {29'h0, arm1_reg, arm0_reg, run_reg};
               `EBT_REG_STATUS:   reg_rdata <= {26'h0, trig_seen_reg, brk_src_reg,
                                                step_reg, run_reg, halted};
               `EBT_REG_BRK0_LO:  reg_rdata <= brk_lo_reg[0];
               `EBT_REG_BRK0_HI:  reg_rdata <= {21'h0, brk_hi_reg[0]};
               `EBT_REG_BRK1_LO:  reg_rdata <= brk_lo_reg[1];
               `EBT_REG_BRK1_HI:  reg_rdata <= {21'h0, brk_hi_reg[1]};
               `EBT_REG_QUAL0_LO: reg_rdata <= qual_lo_reg[0];
               `EBT_REG_QUAL0_HI: reg_rdata <= {21'h0, qual_hi_reg[0]};
               `EBT_REG_QUAL1_LO: reg_rdata <= qual_lo_reg[1];
               `EBT_REG_QUAL1_HI: reg_rdata <= {21'h0, qual_hi_reg[1]};
               `EBT_REG_TRCFG:    reg_rdata <= {29'h0, tr_en_reg, tmode_reg};
               `EBT_REG_TRPTR:    reg_rdata <= {22'h0, wr_ptr_reg};
               `EBT_REG_TRDATA:   reg_rdata <= trace_mem[rd_ptr_reg][`EBT_TR_W-1:8];
               `EBT_REG_TRCOUNT:  reg_rdata <= {21'h0, count_reg};
               `EBT_REG_TIMER:    reg_rdata <= timer_reg;
               `EBT_REG_SYNC:     reg_rdata <= {28'h0, sync_trcen_reg, sync_runen_reg,
                                                sync_latch_reg, sync_out};
               default:           reg_rdata <= 32'h0;
            endcase
         end
      end
   end

endmodule // ebt_break_trace
`default_nettype wire

// [hdl/ebt_consts.vh]
// constants for the emulator break and trace unit
// assumes: included by the unit and its checker, 10 mhz clock
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH
// register offsets (word index on the plain port)
`define EBT_REG_CTRL      8'h00
`define EBT_REG_STATUS    8'h01
`define EBT_REG_BRK0_LO   8'h02
`define EBT_REG_BRK0_HI   8'h03
`define EBT_REG_BRK1_LO   8'h04
`define EBT_REG_BRK1_HI   8'h05
`define EBT_REG_QUAL0_LO  8'h06
`define EBT_REG_QUAL0_HI  8'h07
`define EBT_REG_QUAL1_LO  8'h08
`define EBT_REG_QUAL1_HI  8'h09
`define EBT_REG_TRCFG     8'h0a
`define EBT_REG_TRPTR     8'h0b
`define EBT_REG_TRDATA    8'h0c
`define EBT_REG_TRCOUNT   8'h0d
`define EBT_REG_TIMER     8'h0e
`define EBT_REG_SYNC      8'h0f
// ctrl write bits
`define EBT_CTRL_RUN      0
`define EBT_CTRL_STEP     1
`define EBT_CTRL_HALT     2
`define EBT_CTRL_ARM0     3
`define EBT_CTRL_ARM1     4
`define EBT_CTRL_TCLR     5
// compare word hi layout: kind in [10:8], compare value for opcode/operand/port in [7:0]
`define EBT_KIND_EXACT    3'h0
`define EBT_KIND_RANGE    3'h1
`define EBT_KIND_OPCODE   3'h2
`define EBT_KIND_PORT     3'h3
`define EBT_KIND_OPVAL    3'h4
`define EBT_KIND_OPADDR   3'h5
// trace modes
`define EBT_TM_FOREVER    2'h0
`define EBT_TM_QUAL       2'h1
`define EBT_TM_PRE        2'h2
`define EBT_TM_POST       2'h3
// trace sizing
`define EBT_TR_DEPTH      1000
`define EBT_TR_LAST       10'h3e7
`define EBT_TR_AW         10
`define EBT_TR_W          40
// timer: microseconds at 10 mhz
`define EBT_CLK_HZ        10000000
`define EBT_US_CYCLES     (`EBT_CLK_HZ / 1000000)
`define EBT_US_LAST       4'h9
// sync register bits
`define EBT_SYNC_OUT      0
`define EBT_SYNC_LATCH    1
`define EBT_SYNC_RUNEN    2
`define EBT_SYNC_TRCEN    3
`endif

// [tb/ebt_core_model.sv]
// emulation core stand-in: executes one instruction every other cycle while run is high
// assumes: shares the clock of the break unit; the bench reads pc_reg for expectations
`default_nettype none
module ebt_core_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // core side
   input  wire logic        core_run,
   output var  logic        step_done,
   output var  logic [15:0] exec_addr,
   output var  logic [7:0]  exec_opcode,
   output var  logic [7:0]  exec_port,
   output var  logic        fetch_strobe,
   output var  logic [15:0] fetch_addr,
   output var  logic [7:0]  fetch_operand
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] pc_reg;
   wire go = core_run && !step_done;
   // between steps the values are inverted each cycle so stale data never looks valid
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= 16'h0100;
         step_done <= 1'b0;
         fetch_strobe <= 1'b0;
         {exec_addr, exec_opcode, exec_port} <= 32'h0;
         {fetch_addr, fetch_operand} <= 24'h0;
      end else begin
         step_done <= go;
         fetch_strobe <= go;
         if (go) begin
            pc_reg <= pc_reg + 16'h1;
            {exec_addr, exec_opcode, exec_port} <= {pc_reg, pc_reg[7:0] + 8'h10, ~pc_reg[7:0]};
            {fetch_addr, fetch_operand} <= {pc_reg + 16'h1000, pc_reg[7:0]};
         end else begin
            {exec_addr, exec_opcode, exec_port} <= ~{exec_addr, exec_opcode, exec_port};
            {fetch_addr, fetch_operand} <= ~{fetch_addr, fetch_operand};
         end
      end
   end
endmodule // ebt_core_model
`default_nettype wire

// [tb/ebt_properties.sv]
// concurrent checks on the ports of the break and trace unit
// assumes: one clock domain, bound from the testbench top file
`include "ebt_consts.vh"
`default_nettype none
module ebt_properties (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // core and sync
   input wire logic        step_done,
   input wire logic        core_run,
   input wire logic        halted,
   input wire logic        sync_in,
   input wire logic        sync_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [3:0] sync_age_reg;
   logic       sync_q_reg;
   logic       stepping_reg;
   wire ctrl_wr = reg_wr && reg_addr == `EBT_REG_CTRL;
   // the sync pin passes a synchroniser, so its effect lags by a few cycles
   wire halt_cause = step_done || (ctrl_wr && reg_wdata[`EBT_CTRL_HALT]) || sync_age_reg < 4'h8;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_age_reg <= 4'hf;
         sync_q_reg <= 1'b0;
         stepping_reg <= 1'b0;
      end else begin
         sync_q_reg <= sync_in;
         if (sync_in != sync_q_reg) sync_age_reg <= 4'h0;
         else if (sync_age_reg != 4'hf) sync_age_reg <= sync_age_reg + 4'h1;
         if (ctrl_wr && reg_wdata[`EBT_CTRL_STEP] && halted) stepping_reg <= 1'b1;
         else if (step_done) stepping_reg <= 1'b0;
      end
   end
   sequence s_go;
      ctrl_wr && reg_wdata[`EBT_CTRL_RUN] && !reg_wdata[`EBT_CTRL_HALT] && halted;
   endsequence
   sequence s_step_go;
      ctrl_wr && reg_wdata[`EBT_CTRL_STEP] && halted;
   endsequence
   AST_GO_RUNS: assert property (s_go |=> core_run && !halted)
      else $error("run write did not start emulation");
   AST_STEP_RUNS: assert property (s_step_go |=> core_run)
      else $error("step write did not start the core");
   AST_STEP_ENDS: assert property (stepping_reg && step_done |=> halted && !core_run)
      else $error("single step did not stop after one instruction");
   AST_HALT_CAUSE: assert property ($rose(halted) |-> $past(halt_cause))
      else $error("halt entered without a completed instruction or command");
   AST_HALT_WRITE: assert property (ctrl_wr && reg_wdata[`EBT_CTRL_HALT]
      |=> halted && !core_run)
      else $error("halt command ignored");
   AST_RUN_DROP: assert property ($fell(core_run) |-> halted)
      else $error("core stopped without entering the halted state");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside the answer cycle");
   AST_SYNC_OUT: assert property (reg_wr && reg_addr == `EBT_REG_SYNC
      |=> sync_out == $past(reg_wdata[`EBT_SYNC_OUT]))
      else $error("sync output does not follow its write");
   AST_RESET_STATE: assert property ($rose(rst_n) |-> halted && !core_run)
      else $error("not halted after reset");
endmodule // ebt_properties
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the break and trace unit
// assumes: core model on the core side, sync pin and register port driven here
`include "ebt_consts.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        sync_in = 1'b0;
   logic [31:0] reg_rdata, d;
   logic [15:0] exec_addr, fetch_addr;
   logic [7:0]  exec_opcode, exec_port, fetch_operand;
   logic        step_done, fetch_strobe, core_run, halted, sync_out;
   int          err_count = 0;
   int          samples_checked = 0;
   always #50 clock = ~clock;
   ebt_break_trace u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .step_done(step_done), .exec_addr(exec_addr), .exec_opcode(exec_opcode),
      .exec_port(exec_port), .fetch_strobe(fetch_strobe), .fetch_addr(fetch_addr),
      .fetch_operand(fetch_operand), .core_run(core_run), .halted(halted),
      .sync_in(sync_in), .sync_out(sync_out));
   ebt_core_model u_core (.clock(clock), .rst_n(rst_n), .core_run(core_run),
      .step_done(step_done), .exec_addr(exec_addr), .exec_opcode(exec_opcode),
      .exec_port(exec_port), .fetch_strobe(fetch_strobe), .fetch_addr(fetch_addr),
      .fetch_operand(fetch_operand));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wait_halt();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (halted !== 1'b1 && n < 3000);
      chk({31'h0, halted}, 32'h1, "halt");
   endtask
   task automatic t_reset();
      rd(`EBT_REG_STATUS, d);
      chk(d, 32'h1, "status after reset");
      rd(8'h40, d);
      chk(d, 32'h0, "unmapped read");
   endtask
   // one kind per pass, alternating comparators; target is two steps ahead
   task automatic t_kinds();
      logic [15:0] t;
      logic [31:0] lo, hi;
      for (int k = 0; k < 6; k++) begin
         t = u_core.pc_reg + 16'h2;
         lo = {16'h0, t};
         hi = {21'h0, k[2:0], 8'h00};
         case (k)
            1: lo = {t + 16'h2, t};
            2: hi[7:0] = t[7:0] + 8'h10;
            3: hi[7:0] = ~t[7:0];
            4: hi[7:0] = t[7:0];
            5: lo = {16'h0, t + 16'h1000};
            default: ;
         endcase
         wr(k[0] ? `EBT_REG_BRK1_LO : `EBT_REG_BRK0_LO, lo);
         wr(k[0] ? `EBT_REG_BRK1_HI : `EBT_REG_BRK0_HI, hi);
         wr(`EBT_REG_TRCFG, 32'h4);
         wr(`EBT_REG_CTRL, 32'h20);
         wr(`EBT_REG_CTRL, k[0] ? 32'h11 : 32'h09);
         wait_halt();
         chk({16'h0, u_core.pc_reg}, {16'h0, t + 16'h1}, "brk");
         rd(`EBT_REG_TRCOUNT, d);
         chk(d, 32'h3, "forever frames");
      end
   endtask
   task automatic t_modes();
      logic [15:0] t;
      for (int m = 1; m < 4; m++) begin
         t = u_core.pc_reg;
         wr(`EBT_REG_QUAL0_LO, {16'h0, t + 16'h2});
         wr(`EBT_REG_QUAL0_HI, 32'h0);
         wr(`EBT_REG_BRK0_LO, {16'h0, t + 16'h4});
         wr(`EBT_REG_BRK0_HI, 32'h0);
         wr(`EBT_REG_TRCFG, 32'h4 | m);
         wr(`EBT_REG_CTRL, 32'h20);
         wr(`EBT_REG_CTRL, 32'h09);
         wait_halt();
         rd(`EBT_REG_TRCOUNT, d);
         chk(d, (m == 1) ? 32'h1 : 32'h2, "mode frames");
      end
   endtask
   task automatic t_step();
      logic [15:0] t;
      wr(`EBT_REG_TRCFG, 32'h4);
      wr(`EBT_REG_CTRL, 32'h20);
      t = u_core.pc_reg;
      wr(`EBT_REG_CTRL, 32'h2);
      wait_halt();
      chk({16'h0, u_core.pc_reg}, {16'h0, t + 16'h1}, "one step");
      wr(`EBT_REG_TRPTR, 32'h0);
      rd(`EBT_REG_TRDATA, d);
      chk(d, {~t[7:0], t[7:0] + 8'h10, t}, "step frame");
   endtask
   // 1101 steps overfill the buffer and wrap the write pointer to 101; run spans 2202 cycles
   task automatic t_fill();
      wr(`EBT_REG_CTRL, 32'h20);
      wr(`EBT_REG_CTRL, 32'h1);
      repeat (2200) @(posedge clock);
      wr(`EBT_REG_CTRL, 32'h4);
      rd(`EBT_REG_TRCOUNT, d);
      chk(d, 32'd1000, "full buffer");
      rd(`EBT_REG_TRPTR, d);
      chk(d, 32'd101, "wrapped pointer");
      rd(`EBT_REG_TIMER, d);
      chk({31'h0, d >= 32'd219 && d <= 32'd221}, 32'h1, "timer us");
   endtask
   task automatic t_sync();
      wr(`EBT_REG_SYNC, 32'h1);
      #1 chk({31'h0, sync_out}, 32'h1, "sync out");
      @(posedge clock);
      sync_in <= 1'b1;
      repeat (3) @(posedge clock);
      sync_in <= 1'b0;
      rd(`EBT_REG_SYNC, d);
      chk(d, 32'h3, "sync latched");
      wr(`EBT_REG_SYNC, 32'h2);
      rd(`EBT_REG_SYNC, d);
      chk(d, 32'h0, "latch cleared");
      wr(`EBT_REG_SYNC, 32'h4);
      sync_in <= 1'b1;
      repeat (8) @(posedge clock);
      chk({31'h0, core_run}, 32'h1, "sync start");
      sync_in <= 1'b0;
      wait_halt();
      wr(`EBT_REG_SYNC, 32'h8);
      wr(`EBT_REG_TRCFG, 32'h0);
      sync_in <= 1'b1;
      repeat (4) @(posedge clock);
      rd(`EBT_REG_TRCFG, d);
      chk(d, 32'h4, "sync trace on");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_kinds();
      t_modes();
      t_step();
      t_fill();
      t_sync();
      give_verdict();
   end
   // the sequence needs under 4000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      give_verdict();
   end
endmodule // testbench
bind ebt_break_trace ebt_properties u_props (.clock(clock), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .step_done(step_done), .core_run(core_run), .halted(halted),
   .sync_in(sync_in), .sync_out(sync_out));
`default_nettype wire
